//--- src/dss_pkg.sv
package dss_pkg;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCL_MAX_KHZ   = 400;
  localparam int PROG_TIME_US  = 5000;
  localparam int PROG_CYCLES   = PROG_TIME_US * (1000000 / CLK_PERIOD_PS);

  // Protocol
  localparam logic [7:0] ADDR_BYTE  = 8'h9E;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam int         BYTE_BITS  = 8;
  localparam int         FIFO_DEPTH = 32;
  localparam logic [6:0] DAC_RST    = 7'h00;

  typedef enum logic [2:0] {
    ST_LOAD    = 3'h0,
    ST_IDLE    = 3'h1,
    ST_ADDR    = 3'h2,
    ST_ACK     = 3'h3,
    ST_WR_DATA = 3'h4,
    ST_RD_DATA = 3'h5,
    ST_RD_ACK  = 3'h6,
    ST_IGNORE  = 3'h7
  } dss_state_e;

  typedef struct packed {
    logic [6:0] setting;
    logic       pflag;
  } dss_byte_s;

  typedef struct packed {
    logic bit_q;
    logic tgl_q;
  } dss_link_s;

  typedef struct packed {
    dss_state_e st;
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    logic       tg_m;
    logic       tg_s;
    logic       tg_p;
    logic       permit_m;
    logic       permit_s;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       rw;
    logic       ph;
    logic       more;
    logic       oe;
    logic       sda_lvl;
    logic       push_v;
    dss_byte_s  push_d;
    logic [6:0] dac;
    logic       busy;
    logic [31:0] pcnt;
    logic       nvm_start;
    logic [6:0] nvm_data;
  } dss_sys_s;

  localparam dss_link_s LINK_RST = '0;
  localparam dss_sys_s  SYS_RST  = '{st: ST_LOAD, dac: DAC_RST, default: '0};

endpackage : dss_pkg

//--- src/dss_fifo.sv
`timescale 1ns/1ps
module dss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } dss_fifo_s;

  dss_fifo_s s;
  dss_fifo_s n;
  logic      push;
  logic      pop;

  assign in_ready  = (s.cnt != FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    // Simultaneous push and pop leave the count alone
    if (push && !pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule : dss_fifo

//--- src/dss_top.sv
`timescale 1ns/1ps
module dss_top #(
  parameter int PROG_CYCLES = dss_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH  = dss_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Serial bus, clock line used as link clock
  input  wire logic       scl_clk,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Memory programming permit pin
  input  wire logic       eeprom_write_permit,
  // Non-volatile store
  input  wire logic [6:0] nvm_stored,
  output logic            nvm_prog_start,
  output logic [6:0]      nvm_prog_data,
  // Setting and status
  output logic [6:0]      dac_setting,
  output logic            prog_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: samples data at each serial clock rising edge

  dss_pkg::dss_link_s l;
  dss_pkg::dss_link_s ln;

  // Bit and toggle, captured on every clock rise
  always_comb begin
    ln = l;
    ln.bit_q = sda_i;
    ln.tgl_q = ~l.tgl_q;
  end

  // Bit held a full clock period, so the toggle qualifies it safely
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      l <= dss_pkg::LINK_RST;
    end else begin
      l <= ln;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain state

  dss_pkg::dss_sys_s  s;
  dss_pkg::dss_sys_s  n;
  logic               start_evt;
  logic               stop_evt;
  logic               scl_fall;
  logic               bit_evt;
  logic               rx_bit;
  logic [7:0]         byte_in;
  logic [7:0]         rd_byte;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  logic [7:0]         fifo_out_raw;
  dss_pkg::dss_byte_s fifo_out;

  assign start_evt = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
  assign stop_evt  = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
  // Edge and bit events from the synchronisers
  assign scl_fall  = s.scl_p & ~s.scl_s;
  assign bit_evt   = s.tg_s ^ s.tg_p;
  assign rx_bit    = l.bit_q;
  assign byte_in   = {s.sh[6:0], rx_bit};
  assign rd_byte   = {s.dac, ~s.busy};
  assign fifo_out  = dss_pkg::dss_byte_s'(fifo_out_raw);

  // Drain stalls while programming, so the buffer genuinely fills
  assign fifo_out_ready = ~s.busy & (s.st != dss_pkg::ST_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer

  // Queue lets writes arrive during programming
  dss_fifo #(
    .WIDTH (dss_pkg::BYTE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (s.push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (s.push_d),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = s;
    // two-stage sync; fast-mode low time far exceeds this lag
    n.scl_m    = scl_clk;
    n.scl_s    = s.scl_m;
    n.scl_p    = s.scl_s;
    n.sda_m    = sda_i;
    n.sda_s    = s.sda_m;
    n.sda_p    = s.sda_s;

    // Toggle pair qualifies the link bit
    n.tg_m     = l.tgl_q;
    n.tg_s     = s.tg_m;
    n.tg_p     = s.tg_s;

    // Permit pin, used only when a byte is applied
    n.permit_m = eeprom_write_permit;
    n.permit_s = s.permit_m;

    // Strobes last one cycle unless set below
    n.push_v    = 1'b0;
    n.nvm_start = 1'b0;
    n.sda_lvl   = 1'b0;

    // Programming timer
    if (s.busy) begin
      n.pcnt = s.pcnt - 32'h1;
      if (s.pcnt == 32'h1) begin
        n.busy = 1'b0;
      end
    end

    // Apply buffered writes in order
    if (fifo_out_valid && fifo_out_ready) begin
      n.dac = fifo_out.setting;
      if (!fifo_out.pflag && s.permit_s) begin
        n.busy      = 1'b1;
        n.pcnt      = 32'(PROG_CYCLES);
        n.nvm_start = 1'b1;
        n.nvm_data  = fifo_out.setting;
      end
    end

    // Byte engine, one state per bus phase
    unique case (s.st)
      // Copy the stored value once
      dss_pkg::ST_LOAD: begin
        n.dac = nvm_stored;
        n.st  = dss_pkg::ST_IDLE;
      end

      // Bus free, pin released
      dss_pkg::ST_IDLE: begin
        n.oe = 1'b0;
      end

      // Shift in address and direction
      dss_pkg::ST_ADDR: begin
        if (bit_evt) begin
          n.sh  = byte_in;
          n.cnt = s.cnt + 3'h1;
          if (s.cnt == dss_pkg::LAST_BIT) begin
            if (byte_in[7:1] == dss_pkg::ADDR_BYTE[7:1]) begin
              n.rw = byte_in[0];
              n.ph = 1'b0;
              n.st = dss_pkg::ST_ACK;
            end else begin
              n.st = dss_pkg::ST_IGNORE;
            end
          end
        end
      end

      // Two falls: drive low, then hand over
      dss_pkg::ST_ACK: begin
        if (scl_fall) begin
          if (!s.ph) begin
            n.oe = 1'b1;
            n.ph = 1'b1;
          end else begin
            n.cnt = 3'h0;
            if (s.rw) begin
              n.tx = rd_byte;
              n.oe = ~rd_byte[7];
              n.st = dss_pkg::ST_RD_DATA;
            end else begin
              n.oe = 1'b0;
              n.st = dss_pkg::ST_WR_DATA;
            end
          end
        end
      end

      // Shift in a setting byte
      dss_pkg::ST_WR_DATA: begin
        if (bit_evt) begin
          n.sh  = byte_in;
          n.cnt = s.cnt + 3'h1;
          if (s.cnt == dss_pkg::LAST_BIT) begin
            // Full buffer: refuse the byte with no acknowledge
            if (fifo_in_ready) begin
              n.push_v = 1'b1;
              n.push_d = dss_pkg::dss_byte_s'(byte_in);
              n.ph     = 1'b0;
              n.st     = dss_pkg::ST_ACK;
            end else begin
              n.st = dss_pkg::ST_IGNORE;
            end
          end
        end
      end

      // Shift out the read byte
      dss_pkg::ST_RD_DATA: begin
        if (bit_evt) begin
          n.cnt = s.cnt + 3'h1;
          if (s.cnt == dss_pkg::LAST_BIT) begin
            n.ph   = 1'b0;
            n.more = 1'b0;
            n.st   = dss_pkg::ST_RD_ACK;
          end
        end else if (scl_fall) begin
          n.tx = {s.tx[6:0], 1'b0};
          n.oe = ~s.tx[6];
        end
      end

      // Release, then hear the master
      dss_pkg::ST_RD_ACK: begin
        if (scl_fall) begin
          if (!s.ph) begin
            // Release so the master can answer
            n.oe = 1'b0;
            n.ph = 1'b1;
          end else if (s.more) begin
            n.tx   = rd_byte;
            n.oe   = ~rd_byte[7];
            n.cnt  = 3'h0;
            n.more = 1'b0;
            n.st   = dss_pkg::ST_RD_DATA;
          end
        end else if (bit_evt && s.ph) begin
          if (rx_bit) begin
            n.st = dss_pkg::ST_IGNORE;
          end else begin
            n.more = 1'b1;
          end
        end
      end

      // Deaf until start or stop
      dss_pkg::ST_IGNORE: begin
        n.oe = 1'b0;
      end
    endcase

    // Framing overrides any byte in progress
    if (s.st != dss_pkg::ST_LOAD) begin
      // Stop outranks start in the same cycle
      if (stop_evt) begin
        n.oe = 1'b0;
        n.st = dss_pkg::ST_IDLE;
      end else if (start_evt) begin
        n.oe  = 1'b0;
        n.cnt = 3'h0;
        n.st  = dss_pkg::ST_ADDR;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= dss_pkg::SYS_RST;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Data pin is only ever pulled low
  assign sda_o          = s.sda_lvl;
  assign sda_oe         = s.oe;
  assign dac_setting    = s.dac;
  assign prog_busy      = s.busy;
  assign nvm_prog_start = s.nvm_start;
  assign nvm_prog_data  = s.nvm_data;

endmodule : dss_top

//--- sim/dss_top_assertions.sv
`timescale 1ns/1ps
module dss_chk #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // Bus side
  input wire logic       scl_clk,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  // Store and setting
  input wire logic       eeprom_write_permit,
  input wire logic [6:0] nvm_stored,
  input wire logic       nvm_prog_start,
  input wire logic [6:0] nvm_prog_data,
  input wire logic [6:0] dac_setting,
  input wire logic       prog_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] busy_n_q;

  ////////////////////////////////////////////////////////////
  // Counter, as the busy span is far too long for a repetition
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_n_q <= '0;
    end else begin
      busy_n_q <= prog_busy ? busy_n_q + 32'h1 : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////
  oe_pulls_low_a : assert property (sda_oe |-> !sda_o)
    else $error("Data line driven high");
  oe_scl_low_a : assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("Data line moved in clock high");
  prog_pulse_a : assert property (nvm_prog_start |=> !nvm_prog_start)
    else $error("Program start longer than one cycle");
  prog_busy_a : assert property (nvm_prog_start |-> ##[0:1] prog_busy)
    else $error("Busy not raised by program start");
  prog_data_a : assert property (nvm_prog_start |-> ##[0:1] dac_setting == nvm_prog_data)
    else $error("Programmed value differs from setting");
  prog_permit_a : assert property (nvm_prog_start |-> $past(eeprom_write_permit, 3))
    else $error("Program started without permit");
  busy_length_a : assert property ($fell(prog_busy) |-> busy_n_q == PROG_CYCLES)
    else $error("Busy span wrong");
  power_load_a : assert property ($rose(arst_n) |-> ##[1:3] dac_setting == nvm_stored)
    else $error("Stored value not loaded");
endmodule : dss_chk

//--- sim/dss_master.sv
`timescale 1ns/1ps
module dss_master (
  // Link clock
  input  wire logic lclk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      m_oe
);
  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask : tick

  ////////////////////////////////////////////////////////////
  // one bit slot
  task automatic bitx(input logic b, output logic r);
    m_oe = !b;
    tick(2);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(2);
  endtask : bitx

  task automatic start;
    tick(1);
    while (!(sda && scl)) tick(1);
    m_oe = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : start

  task automatic stop;
    m_oe = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    m_oe = 1'b0;
    tick(4);
  endtask : stop

  task automatic restart;
    m_oe = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    m_oe = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : restart

  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(mack, ack);
  endtask : xfer
endmodule : dss_master

//--- sim/test_dss_top.sv
`timescale 1ns/1ps
module test_dss_top;
  localparam int         PROG_N   = 10000;
  localparam logic [6:0] NVM_INIT = 7'h2A;
  logic       sys_clk, arst_n, lclk, permit, sda_oe, sda_o, scl, m_oe, prog_start, busy;
  logic [6:0] nvm_stored, prog_data, dac, last_prog;
  int         fail_count, samples_checked, n_prog;
  wire        sda = (sda_oe ? sda_o : 1'b1) && !m_oe;

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Link clock, phase unrelated to the system clock
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #7.5 lclk = ~lclk;
  end

  dss_top #(.PROG_CYCLES(PROG_N), .FIFO_DEPTH(32)) i_dut (.sys_clk, .arst_n, .scl_clk(scl), .sda_i(sda),
    .sda_o, .sda_oe, .eeprom_write_permit(permit), .nvm_stored, .nvm_prog_start(prog_start),
    .nvm_prog_data(prog_data), .dac_setting(dac), .prog_busy(busy));
  dss_master i_mst (.lclk, .sda, .scl, .m_oe);

  always @(posedge sys_clk) begin
    if (prog_start === 1'b1) begin
      n_prog++;
      last_prog = prog_data;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] acks);
    logic [7:0] rx;
    i_mst.start();
    i_mst.xfer(a, 1'b1, rx, acks[1]);
    i_mst.xfer(d, 1'b1, rx, acks[0]);
    i_mst.stop();
  endtask : wr

  task automatic rd(output logic [7:0] v);
    logic a0, a1;
    i_mst.start();
    i_mst.xfer(8'h9F, 1'b1, v, a0);
    i_mst.xfer(8'hFF, 1'b1, v, a1);
    i_mst.stop();
    check("read ack", {7'h00, a0}, 8'h00);
  endtask : rd

  ////////////////////////////////////////////////////////////
  task automatic t_basic;
    logic [1:0] acks;
    logic [7:0] v;
    check("dac load", {1'b0, dac}, {1'b0, NVM_INIT});
    wr(8'h9E, {7'h55, 1'b1}, acks);
    check("write acks", {6'h00, acks}, 8'h00);
    check("dac first", {1'b0, dac}, 8'h55);
    wr(8'h9E, {7'h2B, 1'b1}, acks);
    check("dac second", {1'b0, dac}, 8'h2B);
    check("no program", n_prog[7:0], 8'h00);
    rd(v);
    check("read byte", v, {7'h2B, 1'b1});
    wr(8'hA0, {7'h7F, 1'b1}, acks);
    check("foreign acks", {6'h00, acks}, 8'h03);
    check("dac kept", {1'b0, dac}, 8'h2B);
    $display("t_basic done");
  endtask : t_basic

  // Programming holds later bytes in the buffer until it overflows
  task automatic t_fill;
    logic [7:0] v;
    logic       a;
    @(posedge sys_clk);
    #1 permit = 1'b1;
    i_mst.start();
    i_mst.xfer(8'h9E, 1'b1, v, a);
    i_mst.xfer({7'h33, 1'b0}, 1'b1, v, a);
    for (int i = 1; i <= 33; i++) begin
      i_mst.xfer({7'h40 + 7'(i), 1'b1}, 1'b1, v, a);
      check("fill ack", {7'h00, a}, {7'h00, i == 33});
    end
    i_mst.stop();
    check("prog value", {1'b0, last_prog}, 8'h33);
    rd(v);
    check("busy read", v, {7'h33, 1'b0});
    for (int n = 0; n < 40 && v[0] !== 1'b1; n++) rd(v);
    // One more read, clear of the buffer drain after busy drops
    rd(v);
    check("ready read", v, {7'h60, 1'b1});
    check("prog count", n_prog[7:0], 8'h01);
    $display("t_fill done");
  endtask : t_fill

  task automatic t_noperm;
    logic [1:0] acks;
    @(posedge sys_clk);
    #1 permit = 1'b0;
    wr(8'h9E, {7'h11, 1'b0}, acks);
    check("dac no permit", {1'b0, dac}, 8'h11);
    check("prog refused", n_prog[7:0], 8'h01);
    $display("t_noperm done");
  endtask : t_noperm

  // Write, repeated start, then a two-byte read
  task automatic t_multi;
    logic [7:0] v0;
    logic [7:0] v1;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    i_mst.start();
    i_mst.xfer(8'h9E, 1'b1, v0, a0);
    i_mst.xfer({7'h4C, 1'b1}, 1'b1, v0, a1);
    i_mst.restart();
    i_mst.xfer(8'h9F, 1'b1, v0, a2);
    i_mst.xfer(8'hFF, 1'b0, v0, a3);
    i_mst.xfer(8'hFF, 1'b1, v1, a3);
    i_mst.stop();
    check("restart acks", {5'h00, a0, a1, a2}, 8'h00);
    check("first of two", v0, {7'h4C, 1'b1});
    check("second of two", v1, {7'h4C, 1'b1});
    $display("t_multi done");
  endtask : t_multi

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////
  initial begin
    arst_n          = 1'b1;
    permit          = 1'b0;
    nvm_stored      = NVM_INIT;
    fail_count      = 0;
    samples_checked = 0;
    n_prog          = 0;
    last_prog       = 7'h00;
    // Falling edge after time zero, so every reset branch sees it
    #1 arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_basic();
    t_fill();
    t_noperm();
    t_multi();
    tally_and_finish();
  end

  // Whole run needs about 75 us
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule : test_dss_top

bind dss_top dss_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.sys_clk, .arst_n, .scl_clk, .sda_o, .sda_oe,
  .eeprom_write_permit, .nvm_stored, .nvm_prog_start, .nvm_prog_data, .dac_setting, .prog_busy);
